// ### hw/sar_adc_regs.vh
// Constants of the serial readout block: timing counts and result width.
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH
// ==========================================================
// Timing
`define CLK_PERIOD_NS        10
`define CONVERSION_TIME_NS   1300
`define CONVERSION_CYCLES    ((`CONVERSION_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define APERTURE_DELAY_NS    10
`define APERTURE_CYCLES      ((`APERTURE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CALIBRATION_TIME_MS  500
`define CALIBRATION_CYCLES   (`CALIBRATION_TIME_MS * 100000)
`define RECAL_PULSES         1024
// ==========================================================
// Result word
`define RESULT_BITS          16
`endif

// ### hw/sar_adc_serial_readout.v
// Conversion control, serial readout and recalibration of a SAR converter.
// How it works
// RULE1: rising edge of convert_start_select starts a conversion and holds the sample.
// RULE2: conversion runs to its end whatever convert_start_select does meanwhile.
// RULE3: one pin serves as chip select and as conversion start.
// RULE4: after conversion, low convert_start_select enables the output with the result; the code opens it only on a fall seen in ST_READY.
// RULE5: result leaves MSB first, changing on each falling serial clock edge.
// RULE6: output floats after the last bit or when the select rises.
// RULE7: host may capture on either serial clock edge; falling is faster.
// RULE8: host holds the serial data input high.
// RULE9: result is unipolar straight binary, rising with the input.
// RULE10: above reference minus one LSB gives all ones; below zero all zeros.
// RULE11: half reference gives MSB one and all other bits zero.
// RULE12: conversion time is fixed at 1300 ns, host cannot shorten it.
// RULE13: host sets acquisition time by when it raises the select again.
// RULE14: host clocks fast enough to read every bit within acquisition.
// RULE15: 1024 serial clock pulses in acquisition request self-calibration.
// RULE16: output low during calibration, released to high impedance after.
// RULE17: self-calibration lasts about 500 ms.
// RULE18: sample is held only after a short aperture delay.
// RULE19: host leaves quiet time before the next conversion start.
// RULE20: result width is 16, 14 or 12 bits, all shifted per conversion.
// RULE21: pulses are counted per acquisition; short bursts are reads, 1024 calibrates.
`timescale 1ns/100ps
`include "sar_adc_regs.vh"
module sar_adc_serial_readout #(
	parameter N            = `RESULT_BITS,
	parameter CAL_CYCLES   = `CALIBRATION_CYCLES,
	parameter CONV_CYCLES  = `CONVERSION_CYCLES,
	parameter APER_CYCLES  = `APERTURE_CYCLES,
	parameter RECAL_COUNT  = `RECAL_PULSES
) (
	// Clock, reset, enable
	input  wire         clk,
	input  wire         arst_n,
	input  wire         ce,
	// Analog stand-in: sample scaled so full reference equals 2**N
	input  wire [N:0]   analog_level,
	input  wire         analog_negative,
	// Serial pins
	input  wire         convert_start_select,
	input  wire         sclk,
	input  wire         sdi,
	output wire         sdo_out,
	output wire         sdo_oe,
	// Status
	output wire         busy,
	output wire         calibrating
);
	// ==========================================================
	// Pin synchronisation
	wire cs_s;
	wire sclk_s;
	wire sdi_s;
	sar_sync u_cs (
		.clk   (clk),
		.arst_n(arst_n),
		.ce    (ce),
		.din   (convert_start_select),
		.dout  (cs_s)
	);

	sar_sync u_sclk (
		.clk   (clk),
		.arst_n(arst_n),
		.ce    (ce),
		.din   (sclk),
		.dout  (sclk_s)
	);

	sar_sync u_sdi (
		.clk   (clk),
		.arst_n(arst_n),
		.ce    (ce),
		.din   (sdi),
		.dout  (sdi_s)
	);

	reg cs_d;
	reg sclk_d;
	wire cs_rise   = cs_s & ~cs_d;
	wire cs_fall   = ~cs_s & cs_d;
	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;

	// The delayed copies reset to the idle low level of both pins, so no false edge follows reset.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_d   <= 1'b0;
			sclk_d <= 1'b0;
		end else if (ce) begin
			cs_d   <= cs_s;
			sclk_d <= sclk_s;
		end
	end

	// ==========================================================
	// Quantizer
	wire [N-1:0] code;
	sar_quantizer #(.N(N)) u_quant (
		.level   (analog_level),
		.negative(analog_negative),
		.code    (code)
	);

	// ==========================================================
	// State machine
	localparam ST_ACQ   = 3'd0;
	localparam ST_APER  = 3'd1;
	localparam ST_CONV  = 3'd2;
	localparam ST_READY = 3'd3;
	localparam ST_SHIFT = 3'd4;
	localparam ST_CAL   = 3'd5;

	reg  [2:0]   state;
	reg  [2:0]   next_state;
	reg  [26:0]  timer;
	reg  [N-1:0] shift;
	reg  [5:0]   bits_left;
	reg  [10:0]  pulses;
	reg          drive;
	reg          data_out;

	// Events of the current cycle, decoded once and shared by the processes below.
	wire         in_acq;
	wire         pulses_full;
	wire         start_hit;
	wire         recal_hit;
	wire         open_hit;
	wire         step_hit;
	wire         last_bit;
	wire         timed_phase;
	wire         aper_done;
	wire         conv_done;
	wire         cal_done;
	wire         state_bad;

	// The same pin opens the read window and starts the next conversion.
	assign in_acq      = (state == ST_ACQ) || (state == ST_READY) || (state == ST_SHIFT);
	assign pulses_full = (pulses == RECAL_COUNT[10:0] - 11'h1);
	assign start_hit   = in_acq && cs_rise; //RULE3
	assign recal_hit   = in_acq && !cs_rise && sclk_rise && pulses_full; //RULE15
	assign open_hit    = (state == ST_READY) && !cs_rise && !recal_hit && cs_fall; //RULE4
	assign step_hit    = (state == ST_SHIFT) && !cs_rise && sclk_fall && drive; //RULE5
	assign last_bit    = (bits_left == 6'h1);
	assign timed_phase = (state == ST_APER) || (state == ST_CONV) || (state == ST_CAL);
	assign aper_done   = (state == ST_APER) && (timer >= APER_CYCLES - 1); //RULE18
	assign conv_done   = (state == ST_CONV) && (timer >= CONV_CYCLES - 1); //RULE12
	assign cal_done    = (state == ST_CAL) && (timer >= CAL_CYCLES - 1); //RULE17
	assign state_bad   = (state > ST_CAL);

	always @* begin
		next_state = state;
		case (state)
			ST_ACQ, ST_READY, ST_SHIFT: begin
				if (start_hit) begin
					next_state = ST_APER; //RULE1
				end else if (recal_hit) begin
					next_state = ST_CAL; //RULE21
				end else if (open_hit) begin
					next_state = ST_SHIFT; //RULE4
				end
			end
			ST_APER: begin
				if (aper_done) begin
					next_state = ST_CONV; //RULE18
				end
			end
			ST_CONV: begin
				// The select pin is not looked at here; conversion always runs its full length.
				if (conv_done) begin
					next_state = ST_READY; //RULE2
				end
			end
			ST_CAL: begin
				if (cal_done) begin
					next_state = ST_ACQ; //RULE16
				end
			end
			default: begin
				next_state = ST_ACQ;
			end
		endcase
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_ACQ;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Phase timer
	// The 27-bit timer covers the 500 ms calibration default at 100 MHz, with room for up to 134217728 cycles, about 1.34 s.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer <= 27'h0;
		end else if (ce) begin
			if (start_hit || recal_hit || aper_done || conv_done || cal_done) begin
				timer <= 27'h0;
			end else if (timed_phase) begin
				timer <= timer + 27'h1; //RULE2
			end
		end
	end

	// ==========================================================
	// Serial clock pulse counter
	// Every rise in acquisition, ready or shift counts, data bits included, so an overlong read burst becomes a recalibration.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pulses <= 11'h0;
		end else if (ce) begin
			if (start_hit || recal_hit || conv_done) begin
				pulses <= 11'h0; //RULE21
			end else if (in_acq && sclk_rise) begin
				pulses <= pulses + 11'h1; //RULE21
			end
		end
	end

	// ==========================================================
	// Result shift register
	// Each bit loads the held sample at the end of the aperture and takes its lower neighbour per step; bit 0 takes zero.
	genvar gi;
	generate
		for (gi = 0; gi < N; gi = gi + 1) begin : g_shift
			wire lower_bit;
			if (gi == 0) begin : g_lsb
				assign lower_bit = 1'b0;
			end else begin : g_upper
				assign lower_bit = shift[gi-1];
			end
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					shift[gi] <= 1'b0;
				end else if (ce) begin
					if (aper_done) begin
						shift[gi] <= code[gi]; //RULE9
					end else if (step_hit && !last_bit) begin
						shift[gi] <= lower_bit; //RULE5
					end
				end
			end
		end
	endgenerate

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bits_left <= 6'h0;
		end else if (ce) begin
			if (open_hit) begin
				bits_left <= N[5:0]; //RULE20
			end else if (step_hit) begin
				if (last_bit) begin
					bits_left <= 6'h0;
				end else begin
					bits_left <= bits_left - 6'h1; //RULE20
				end
			end
		end
	end

	// ==========================================================
	// Serial output drive
	// A select lowered before the conversion ends opens nothing; only a fall seen when ready does.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			drive <= 1'b0;
		end else if (ce) begin
			if (start_hit) begin
				drive <= 1'b0; //RULE6
			end else if (recal_hit) begin
				drive <= 1'b1; //RULE16
			end else if (open_hit) begin
				drive <= 1'b1; //RULE4
			end else if (step_hit && last_bit) begin
				drive <= 1'b0; //RULE6
			end else if (cal_done || state_bad) begin
				drive <= 1'b0; //RULE16
			end
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_out <= 1'b0;
		end else if (ce) begin
			if (recal_hit) begin
				data_out <= 1'b0; //RULE16
			end else if (open_hit) begin
				data_out <= shift[N-1]; //RULE5
			end else if (step_hit && !last_bit) begin
				data_out <= shift[N-2]; //RULE5
			end
		end
	end

	// ==========================================================
	// Outputs
	assign sdo_out     = data_out;
	assign sdo_oe      = drive;
	assign busy        = (state == ST_APER) || (state == ST_CONV);
	assign calibrating = (state == ST_CAL);
	// The serial data input is expected high and is not otherwise used.
	wire unused_sdi = sdi_s;
endmodule

// ### hw/sar_quantizer.v
// Maps a sampled input, held in reference units, onto an unsigned straight-binary code.
`timescale 1ns/100ps
module sar_quantizer #(
	parameter N = 16
) (
	// Sample in, scaled so that full reference is 2**N; negative values arrive as a flag
	input  wire [N:0]   level,
	input  wire         negative,
	// Code out
	output reg  [N-1:0] code
);
	always @* begin
		if (negative) begin
			code = {N{1'b0}}; //RULE10
		end else if (level[N]) begin
			code = {N{1'b1}}; //RULE10
		end else begin
			code = level[N-1:0]; //RULE9 RULE11
		end
	end
endmodule

// ### hw/sar_sync.v
// Two-stage synchroniser for one pin input.
`timescale 1ns/100ps
module sar_sync (
	// Clock and reset
	input  wire clk,
	input  wire arst_n,
	input  wire ce,
	// Data
	input  wire din,
	output wire dout
);
	reg meta;
	reg stable;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta   <= 1'b0;
			stable <= 1'b0;
		end else if (ce) begin
			meta   <= din;
			stable <= meta;
		end
	end
	assign dout = stable;
endmodule

// ### testbench/sar_adc_serial_readout_tb_top.sv
// Top testbench of the serial readout block.
`timescale 1ns/100ps
`define CHK(s, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", s, e, g); end end
module sar_adc_serial_readout_tb_top;
	// ====
	// Signals
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [16:0] analog_level = 17'h0;
	logic        analog_negative = 1'b0;
	logic        ce = 1'b1;
	logic [15:0] w;
	int          miscompares = 0;
	int          n_checks = 0;
	wire         convert_start_select, sclk, sdi, sdo_out, sdo_oe, busy, calibrating;
	wire         sdo_line = sdo_oe ? sdo_out : 1'b1;
	initial begin
		forever #5 clk = ~clk;
	end
	sar_adc_serial_readout #(.CAL_CYCLES(200)) dut_u (.*);
	sar_host_model host_u (.*);
	// ====
	// Scenarios
	task automatic t_codes;
		logic [16:0] lv [6] = '{17'h0, 17'h1, 17'h8000, 17'hffff, 17'h10000, 17'h8000};
		logic [15:0] ex [6] = '{16'h0, 16'h1, 16'h8000, 16'hffff, 16'hffff, 16'h0};
		for (int i = 0; i < 6; i++) begin
			analog_level = lv[i];
			analog_negative = (i == 5);
			host_u.convert(16, w);
			`CHK("code", ex[i], w)
			`CHK("released", 1'b0, sdo_oe)
		end
		analog_negative = 1'b0;
	endtask
	task automatic t_hold;
		analog_level = 17'h1234;
		fork
			host_u.convert(16, w);
			begin
				repeat (30) @(negedge clk);
				analog_level = 17'h0;
				host_u.dip_select(20);
				`CHK("still busy", 1'b1, busy)
			end
		join
		`CHK("held", 16'h1234, w)
	endtask
	task automatic t_short;
		analog_level = 17'hab5c;
		host_u.convert(8, w);
		`CHK("top byte", 8'hab, w[7:0])
		`CHK("driving", 1'b1, sdo_oe)
		`CHK("no cal", 1'b0, calibrating)
		ce = 1'b0;
		host_u.pulses(8, w);
		ce = 1'b1;
		host_u.pulses(8, w);
		`CHK("low byte after freeze", 8'h5c, w[7:0])
	endtask
	task automatic t_recal;
		host_u.convert(16, w);
		host_u.pulses(1007, w);
		repeat (5) @(negedge clk);
		`CHK("cal early", 1'b0, calibrating)
		host_u.pulses(1, w);
		repeat (5) @(negedge clk);
		`CHK("cal sdo", 1'b0, sdo_line)
		repeat (200) @(negedge clk);
		`CHK("cal done", 1'b1, sdo_line)
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		t_codes();
		t_hold();
		t_short();
		t_recal();
		complete_run();
	end
	initial begin
		#300000;
		miscompares++;
		complete_run();
	end
endmodule

// ### testbench/sar_host_model.sv
// Host model: drives select, serial clock and data-in, gathers sdo.
`timescale 1ns/100ps
module sar_host_model (
	// Clock and sensed line
	input  wire clk,
	input  wire sdo_line,
	// Driven pins
	output reg  convert_start_select = 1'b0,
	output reg  sclk = 1'b0,
	output reg  sdi = 1'b1
);
	// ====
	// Transfers
	// Serial clock of 80 ns, resting low between frames.
	task automatic pulses(input int n, output logic [15:0] w);
		w = 16'h0;
		repeat (n) begin
			repeat (4) @(negedge clk);
			sclk = 1'b1;
			w = {w[14:0], sdo_line};
			repeat (4) @(negedge clk);
			sclk = 1'b0;
		end
	endtask
	// A dip of the select in mid-conversion must leave the conversion running.
	task automatic dip_select(input int n);
		convert_start_select = 1'b0;
		repeat (n) @(negedge clk);
		convert_start_select = 1'b1;
	endtask
	// Lowering the select before the end would not open the output, so wait it out.
	task automatic convert(input int n, output logic [15:0] w);
		@(negedge clk);
		convert_start_select = 1'b1;
		repeat (140) @(negedge clk);
		convert_start_select = 1'b0;
		pulses(n, w);
		repeat (5) @(negedge clk);
	endtask
endmodule

// ### testbench/sar_readout_chk.sv
// Port timing checks of the serial readout block.
`timescale 1ns/100ps
module sar_readout_chk (
	// Clock and reset
	input logic clk,
	input logic arst_n,
	// Pins and status
	input logic convert_start_select,
	input logic sclk,
	input logic sdo_out,
	input logic sdo_oe,
	input logic busy,
	input logic calibrating
);
	// ====
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_cal; calibrating |-> sdo_oe && !sdo_out; endproperty
	a_cal: assert property (p_cal) else $error("sdo not low in cal");
	property p_calt; $rose(calibrating) |-> ##199 calibrating ##[1:3] !calibrating; endproperty
	a_calt: assert property (p_calt) else $error("cal length");
	property p_conv; $rose(busy) |-> ##129 busy ##[1:3] !busy; endproperty
	a_conv: assert property (p_conv) else $error("conv length");
	property p_start; $rose(convert_start_select) && !busy && !calibrating |-> ##[1:6] busy; endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_rel; $rose(convert_start_select) && !calibrating |-> ##[1:5] !sdo_oe; endproperty
	a_rel: assert property (p_rel) else $error("no release");
	property p_quiet; busy |-> !sdo_oe; endproperty
	a_quiet: assert property (p_quiet) else $error("drive in conv");
	property p_open; $rose(sdo_oe) && !calibrating |-> !convert_start_select && !busy; endproperty
	a_open: assert property (p_open) else $error("bad open");
	// The pin is sampled late, so a new bit shows while the serial clock is still low.
	property p_edge; sdo_oe && $past(sdo_oe) && $changed(sdo_out) && !calibrating |-> !sclk; endproperty
	a_edge: assert property (p_edge) else $error("bit moved off fall");
endmodule
bind sar_adc_serial_readout sar_readout_chk chk_u (.*);
